// file: logic/ctl_chan_pkg.sv
// Shared constants and carrier types for the control-channel I2C support block
package ctl_chan_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_I2C_CONTROL_TWO      = 8'h06;
	localparam logic [7:0] OFS_REMOTE_SERIALIZER_ID = 8'h07;
	localparam logic [7:0] OFS_REMOTE_SLAVE_ADDR_0  = 8'h08;
	localparam logic [7:0] OFS_REMOTE_SLAVE_ADDR_1  = 8'h09;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_I2C_CONTROL_TWO      = 8'h00;
	localparam logic [7:0] RST_REMOTE_SERIALIZER_ID = 8'h00;
	localparam logic [7:0] RST_REMOTE_SLAVE_ADDR    = 8'h00;
	localparam logic [7:0] READ_ZERO                = 8'h00;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int SEQ_ERR_BIT   = 7;
	localparam int SEQ_CLR_BIT   = 6;
	localparam int RSVD_BIT      = 5;
	localparam int SDA_DLY_HI    = 4;
	localparam int SDA_DLY_LO    = 3;
	localparam int WR_BLOCK_BIT  = 2;
	localparam int WD_FAST_BIT   = 1;
	localparam int WD_OFF_BIT    = 0;
	localparam int ADDR_HI       = 7;
	localparam int ADDR_LO       = 1;
	localparam int HOLD_BIT      = 0;
	localparam int ADDR_W        = 7;
	localparam int SDA_DLY_W     = 2;

	localparam logic [ADDR_W-1:0] ADDR_NONE = 7'h00;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int WD_FAST_US     = 50;
	localparam int WD_SLOW_S      = 1;
	localparam int WD_CNT_W       = 24;
	localparam logic [WD_CNT_W-1:0] WD_FAST_CYC =
		WD_CNT_W'((WD_FAST_US * 1000) / CLK_PERIOD_NS);
	localparam logic [WD_CNT_W-1:0] WD_SLOW_CYC =
		WD_CNT_W'((WD_SLOW_S * 1000000000) / CLK_PERIOD_NS);
	localparam int SDA_BASE_NS    = 250;
	localparam int SDA_STEP_NS    = 50;
	localparam int RECOV_HALF_NS  = 5000;
	localparam int RECOV_HALF_CYC = (RECOV_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_PULSES   = 9;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       remote;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
	} txn_t;

endpackage

// file: logic/sda_out_delay.sv
// Programmable SCL-to-SDA output delay line
`timescale 1ns/1ns
module sda_out_delay #(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 arst_n,
	// Control
	input  wire logic [ctl_chan_pkg::SDA_DLY_W-1:0]   dly_code,
	input  wire logic                                 drive_low,
	// Delayed drive
	output logic                                      drive_low_dly
);
	import ctl_chan_pkg::*;

	logic [DEPTH-1:0] line_r;
	int               ns_v;
	int               tap_v;
	logic [1:0]       tap;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			line_r <= '0;
		end else begin
			line_r <= {line_r[DEPTH-2:0], drive_low};
		end
	end

	// Rounded up to whole cycles; line input, tap and pin flops add three
	always_comb begin
		ns_v  = SDA_BASE_NS + SDA_STEP_NS * int'(dly_code);
		tap_v = (ns_v + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 3;
		if (tap_v < 0) begin
			tap_v = 0;
		end
		tap = tap_v[1:0];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_low_dly <= 1'b0;
		end else begin
			drive_low_dly <= line_r[tap];
		end
	end

endmodule // sda_out_delay

// file: logic/bus_watchdog.sv
// I2C bus watchdog: idle detection and SCL clocking recovery
`timescale 1ns/1ns
module bus_watchdog #(
	parameter int                                 CNT_W    = ctl_chan_pkg::WD_CNT_W,
	parameter logic [ctl_chan_pkg::WD_CNT_W-1:0]  FAST_CYC = ctl_chan_pkg::WD_FAST_CYC,
	parameter logic [ctl_chan_pkg::WD_CNT_W-1:0]  SLOW_CYC = ctl_chan_pkg::WD_SLOW_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Control
	input  wire logic wd_off,
	input  wire logic wd_fast,
	// Bus pins, asynchronous
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Status and drive
	output logic      bus_free,
	output logic      recovering,
	output logic      scl_pull
);
	import ctl_chan_pkg::*;

	typedef enum logic [0:0] {
		WD_WATCH   = 1'b0,
		WD_RECOVER = 1'b1
	} wd_state_t;

	wd_state_t        state_r;
	logic             scl_m_r, scl_s_r, scl_p_r;
	logic             sda_m_r, sda_s_r, sda_p_r;
	logic [CNT_W-1:0] idle_r;
	logic [CNT_W-1:0] limit;
	logic [7:0]       half_r;
	logic [3:0]       pulses_r;
	logic             activity;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_p_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_p_r <= sda_s_r;
		end
	end

	assign activity = (scl_s_r ^ scl_p_r) | (sda_s_r ^ sda_p_r);
	assign limit    = wd_fast ? FAST_CYC : SLOW_CYC;
	assign recovering = (state_r == WD_RECOVER);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r  <= WD_WATCH;
			idle_r   <= '0;
			bus_free <= 1'b0;
			scl_pull <= 1'b0;
			half_r   <= 8'h00;
			pulses_r <= 4'h0;
		end else begin
			unique case (state_r)
				WD_WATCH: begin
					scl_pull <= 1'b0;
					if (wd_off || activity) begin
						idle_r   <= '0;
						bus_free <= 1'b0;
					end else if (idle_r >= limit - 1'b1) begin
						if (sda_s_r) begin
							bus_free <= 1'b1;
						end else if (!bus_free) begin
							state_r  <= WD_RECOVER;
							half_r   <= 8'h00;
							pulses_r <= 4'h0;
						end
					end else begin
						idle_r <= idle_r + 1'b1;
					end
				end
				WD_RECOVER: begin
					if (wd_off) begin
						scl_pull <= 1'b0;
						state_r  <= WD_WATCH;
						idle_r   <= '0;
					end else if (half_r == 8'(RECOV_HALF_CYC - 1)) begin
						half_r   <= 8'h00;
						scl_pull <= !scl_pull;
						if (scl_pull) begin
							pulses_r <= pulses_r + 1'b1;
							if (pulses_r == 4'(RECOV_PULSES - 1)) begin
								state_r <= WD_WATCH;
								idle_r  <= '0;
							end
						end
					end else begin
						half_r <= half_r + 1'b1;
					end
				end
			endcase
		end
	end

endmodule // bus_watchdog

// file: logic/ctl_channel_i2c_remap_regs.sv
// Control-channel I2C support: registers, ID load, alias remap, bus watchdog
//
// Function
// - Sequence error sets read-only flag bit 7
// - Writing one to bit 6 clears flag
// - SDA delay 250 to 400 ns, 50 ns steps; rounded up here to whole cycles, 300 or 400 ns
// - Block bit rejects remote writes to registers
// - Block bit leaves remote slave access untouched
// - Watchdog expires 50 us fast, 1 s slow
// - Watchdog disable bit stops watchdog
// - SDA high and idle means bus free
// - SDA low and idle: nine SCL pulses
// - Serializer ID in 7:1, zero blocks access
// - Serializer ID auto-loads after receive lock
// - Freeze bit stops automatic ID loading
// - Slot 0 address replaces alias 0 matches
// - Slot 1 remaps alias 1 likewise
// - Alias compare detects remote target, zero disables
// - Forward only when pass-through and decode match
`timescale 1ns/1ns
module ctl_channel_i2c_remap_regs #(
	parameter logic [ctl_chan_pkg::WD_CNT_W-1:0] WD_FAST_CYC = ctl_chan_pkg::WD_FAST_CYC,
	parameter logic [ctl_chan_pkg::WD_CNT_W-1:0] WD_SLOW_CYC = ctl_chan_pkg::WD_SLOW_CYC,
	parameter int                                SDA_DEPTH   = 4
) (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 arst_n,

	// Register access from the serial control slave
	input  wire ctl_chan_pkg::reg_req_t               reg_req,
	output logic [7:0]                                reg_rdata,
	output logic                                      reg_rvalid,
	output logic                                      reg_wr_rejected,

	// Forward channel events
	input  wire logic                                 seq_err_evt,
	input  wire logic                                 rx_lock,
	input  wire logic                                 id_load_valid,
	input  wire logic [ctl_chan_pkg::ADDR_W-1:0]      id_load_value,

	// Local transaction address decode
	input  wire logic                                 pass_through_en,
	input  wire logic [ctl_chan_pkg::ADDR_W-1:0]      alias_0,
	input  wire logic [ctl_chan_pkg::ADDR_W-1:0]      alias_1,
	input  wire ctl_chan_pkg::txn_t                   txn_in,
	output ctl_chan_pkg::txn_t                        txn_fwd,
	output logic                                      txn_local,

	// I2C pins
	input  wire logic                                 scl_in,
	output logic                                      scl_out,
	output logic                                      scl_oe,
	input  wire logic                                 sda_in,
	output logic                                      sda_out,
	output logic                                      sda_oe,
	input  wire logic                                 sda_drive_low,
	input  wire logic                                 scl_drive_low,

	// Watchdog status
	output logic                                      bus_free,
	output logic                                      bus_recovering
);
	import ctl_chan_pkg::*;

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic                 seq_err_r;
	logic                 seq_clr_r;
	logic [SDA_DLY_W-1:0] sda_dly_r;
	logic                 wr_block_r;
	logic                 wd_fast_r;
	logic                 wd_off_r;
	logic [ADDR_W-1:0]    far_serializer_addr_r;
	logic                 far_addr_hold_r;
	logic [7:0]           remote_slave_addr_0_r;
	logic [7:0]           remote_slave_addr_1_r;

	logic                 wr_ok;
	logic                 wr_ctl;
	logic                 wr_far;
	logic                 lock_seen_r;
	logic [7:0]           rdata_nxt;

	logic                 wd_free;
	logic                 wd_recov;
	logic                 wd_scl_pull;
	logic                 sda_low_dly;

	// ------------------------------------------------------------------
	// Write qualification
	// ------------------------------------------------------------------
	// Only register writes are gated; a remote master reaching slaves on
	// this side never arrives here, so it is unaffected by the block bit.
	assign wr_ok  = reg_req.wr && !(reg_req.remote && wr_block_r);
	assign wr_ctl = wr_ok && (reg_req.addr == OFS_I2C_CONTROL_TWO);
	assign wr_far = wr_ok && (reg_req.addr == OFS_REMOTE_SERIALIZER_ID);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_wr_rejected <= 1'b0;
		end else begin
			reg_wr_rejected <= reg_req.wr && reg_req.remote && wr_block_r;
		end
	end

	// ------------------------------------------------------------------
	// Control register two
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_clr_r  <= RST_I2C_CONTROL_TWO[SEQ_CLR_BIT];
			sda_dly_r  <= RST_I2C_CONTROL_TWO[SDA_DLY_HI:SDA_DLY_LO];
			wr_block_r <= RST_I2C_CONTROL_TWO[WR_BLOCK_BIT];
			wd_fast_r  <= RST_I2C_CONTROL_TWO[WD_FAST_BIT];
			wd_off_r   <= RST_I2C_CONTROL_TWO[WD_OFF_BIT];
		end else if (wr_ctl) begin
			seq_clr_r  <= reg_req.wdata[SEQ_CLR_BIT];
			sda_dly_r  <= reg_req.wdata[SDA_DLY_HI:SDA_DLY_LO];
			wr_block_r <= reg_req.wdata[WR_BLOCK_BIT];
			wd_fast_r  <= reg_req.wdata[WD_FAST_BIT];
			wd_off_r   <= reg_req.wdata[WD_OFF_BIT];
		end
	end

	// Set wins over a clear in the same cycle so no error is lost
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_err_r <= RST_I2C_CONTROL_TWO[SEQ_ERR_BIT];
		end else if (seq_err_evt) begin
			seq_err_r <= 1'b1;
		end else if (wr_ctl && reg_req.wdata[SEQ_CLR_BIT]) begin
			seq_err_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Remote serializer ID
	// ------------------------------------------------------------------
	// Lock must be seen before any supplied ID is taken; losing lock rearms
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_seen_r <= 1'b0;
		end else begin
			lock_seen_r <= rx_lock;
		end
	end

	// Software write takes priority over a load in the same cycle, which
	// is what software expects when it sets the freeze bit alongside
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			far_serializer_addr_r <= RST_REMOTE_SERIALIZER_ID[ADDR_HI:ADDR_LO];
			far_addr_hold_r       <= RST_REMOTE_SERIALIZER_ID[HOLD_BIT];
		end else if (wr_far) begin
			far_serializer_addr_r <= reg_req.wdata[ADDR_HI:ADDR_LO];
			far_addr_hold_r       <= reg_req.wdata[HOLD_BIT];
		end else if (id_load_valid && lock_seen_r && rx_lock && !far_addr_hold_r) begin
			far_serializer_addr_r <= id_load_value;
		end
	end

	// ------------------------------------------------------------------
	// Remote slave physical address slots
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			remote_slave_addr_0_r <= RST_REMOTE_SLAVE_ADDR;
			remote_slave_addr_1_r <= RST_REMOTE_SLAVE_ADDR;
		end else if (wr_ok) begin
			if (reg_req.addr == OFS_REMOTE_SLAVE_ADDR_0) begin
				remote_slave_addr_0_r <= reg_req.wdata;
			end
			if (reg_req.addr == OFS_REMOTE_SLAVE_ADDR_1) begin
				remote_slave_addr_1_r <= reg_req.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	always_comb begin
		rdata_nxt = READ_ZERO;
		unique case (reg_req.addr)
			OFS_I2C_CONTROL_TWO: begin
				rdata_nxt[SEQ_ERR_BIT]            = seq_err_r;
				rdata_nxt[SEQ_CLR_BIT]            = seq_clr_r;
				rdata_nxt[RSVD_BIT]               = 1'b0;
				rdata_nxt[SDA_DLY_HI:SDA_DLY_LO]  = sda_dly_r;
				rdata_nxt[WR_BLOCK_BIT]           = wr_block_r;
				rdata_nxt[WD_FAST_BIT]            = wd_fast_r;
				rdata_nxt[WD_OFF_BIT]             = wd_off_r;
			end
			OFS_REMOTE_SERIALIZER_ID: begin
				rdata_nxt = {far_serializer_addr_r, far_addr_hold_r};
			end
			OFS_REMOTE_SLAVE_ADDR_0: begin
				rdata_nxt = remote_slave_addr_0_r;
			end
			OFS_REMOTE_SLAVE_ADDR_1: begin
				rdata_nxt = remote_slave_addr_1_r;
			end
			default: begin
				rdata_nxt = READ_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata  <= READ_ZERO;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Address decode and remap toward the serializer
	// ------------------------------------------------------------------
	// A zero alias or zero serializer ID never matches, so a general call
	// address can not leak across the link through an unset slot.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txn_fwd   <= '0;
			txn_local <= 1'b0;
		end else begin
			txn_fwd.valid <= 1'b0;
			txn_local     <= 1'b0;
			if (txn_in.valid) begin
				if (pass_through_en && alias_0 != ADDR_NONE && txn_in.addr == alias_0) begin
					txn_fwd.valid <= 1'b1;
					txn_fwd.addr  <= remote_slave_addr_0_r[ADDR_HI:ADDR_LO];
				end else if (pass_through_en && alias_1 != ADDR_NONE
				             && txn_in.addr == alias_1) begin
					txn_fwd.valid <= 1'b1;
					txn_fwd.addr  <= remote_slave_addr_1_r[ADDR_HI:ADDR_LO];
				end else if (pass_through_en && far_serializer_addr_r != ADDR_NONE
				             && txn_in.addr == far_serializer_addr_r) begin
					txn_fwd.valid <= 1'b1;
					txn_fwd.addr  <= txn_in.addr;
				end else begin
					txn_local <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus watchdog and SDA output delay
	// ------------------------------------------------------------------
	bus_watchdog #(
		.CNT_W    (WD_CNT_W),
		.FAST_CYC (WD_FAST_CYC),
		.SLOW_CYC (WD_SLOW_CYC)
	) u_bus_watchdog (
		.clk        (clk),
		.arst_n     (arst_n),
		.wd_off     (wd_off_r),
		.wd_fast    (wd_fast_r),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.bus_free   (wd_free),
		.recovering (wd_recov),
		.scl_pull   (wd_scl_pull)
	);

	sda_out_delay #(
		.DEPTH (SDA_DEPTH)
	) u_sda_out_delay (
		.clk           (clk),
		.arst_n        (arst_n),
		.dly_code      (sda_dly_r),
		.drive_low     (sda_drive_low),
		.drive_low_dly (sda_low_dly)
	);

	// ------------------------------------------------------------------
	// Pin and status outputs
	// ------------------------------------------------------------------
	// Open-drain pins: the output level is always low, enable pulls
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_out        <= 1'b0;
			scl_oe         <= 1'b0;
			sda_out        <= 1'b0;
			sda_oe         <= 1'b0;
			bus_free       <= 1'b0;
			bus_recovering <= 1'b0;
		end else begin
			scl_out        <= 1'b0;
			scl_oe         <= scl_drive_low | wd_scl_pull;
			sda_out        <= 1'b0;
			sda_oe         <= sda_low_dly;
			bus_free       <= wd_free;
			bus_recovering <= wd_recov;
		end
	end

endmodule // ctl_channel_i2c_remap_regs

// file: test/ctl_channel_props.sv
// Port-level assertions for the control-channel I2C support block
`timescale 1ns/1ns
module ctl_channel_props (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   arst_n,
	// Register access
	input wire ctl_chan_pkg::reg_req_t reg_req,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   reg_rvalid,
	input wire logic                   reg_wr_rejected,
	// Transactions
	input wire logic                   pass_through_en,
	input wire ctl_chan_pkg::txn_t     txn_in,
	input wire ctl_chan_pkg::txn_t     txn_fwd,
	input wire logic                   txn_local,
	// Pins and watchdog
	input wire logic                   sda_drive_low,
	input wire logic                   sda_oe,
	input wire logic                   scl_out,
	input wire logic                   sda_out,
	input wire logic                   bus_free,
	input wire logic                   bus_recovering
);
	import ctl_chan_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Recovery length counter; a long count cannot be a repetition
	logic [10:0] rec_cnt_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rec_cnt_r <= '0;
		end else begin
			rec_cnt_r <= bus_recovering ? rec_cnt_r + 11'h001 : 11'h000;
		end
	end

	sequence s_drv_hi;
		sda_drive_low [*5];
	endsequence
	sequence s_drv_lo;
		!sda_drive_low [*5];
	endsequence

	AST_RVALID: assert property (reg_req.rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	AST_REJ_CAUSE: assert property (reg_wr_rejected |-> $past(reg_req.wr && reg_req.remote))
		else $error("reject without a remote write");
	AST_NO_REJ_LOCAL: assert property (reg_req.wr && !reg_req.remote |=> !reg_wr_rejected)
		else $error("local write rejected");
	AST_RDATA_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_TXN_ONE: assert property (txn_in.valid |=> txn_fwd.valid ^ txn_local)
		else $error("transaction not answered exactly once");
	AST_NO_PASS: assert property (txn_in.valid && !pass_through_en |=> !txn_fwd.valid)
		else $error("forwarded with pass-through off");
	AST_ZERO_ADDR: assert property (txn_in.valid && txn_in.addr == 7'h00 |=> !txn_fwd.valid)
		else $error("zero address forwarded");
	AST_SDA_HI: assert property (s_drv_hi |-> sda_oe)
		else $error("sda drive later than four cycles");
	AST_SDA_LO: assert property (s_drv_lo |-> !sda_oe)
		else $error("sda release later than four cycles");
	AST_FREE_EXCL: assert property (bus_free |-> !bus_recovering)
		else $error("free and recovering together");
	AST_RECOV_LEN: assert property ($fell(bus_recovering) |-> $past(rec_cnt_r) inside {[840:920]})
		else $error("recovery length off");
	AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
endmodule // ctl_channel_props

bind ctl_channel_i2c_remap_regs ctl_channel_props u_props (
	.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .reg_wr_rejected(reg_wr_rejected),
	.pass_through_en(pass_through_en), .txn_in(txn_in), .txn_fwd(txn_fwd),
	.txn_local(txn_local), .sda_drive_low(sda_drive_low), .sda_oe(sda_oe),
	.scl_out(scl_out), .sda_out(sda_out), .bus_free(bus_free),
	.bus_recovering(bus_recovering));

// file: test/i2c_far_end.sv
// Far side of the I2C pins: pull-ups and a slave that can hang SDA low
`timescale 1ns/1ns
module i2c_far_end (
	// Device pin drives
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	// Stuck slave control
	input  wire logic hold_sda_low,
	// Wire levels
	output logic      scl_in,
	output logic      sda_in
);
	// Released lines float high through the pull-ups
	assign scl_in = ~scl_oe;
	assign sda_in = ~(sda_oe | hold_sda_low);
endmodule // i2c_far_end

// file: test/tb.sv
// Self-checking bench for the control-channel I2C support block
`timescale 1ns/1ns
module tb;
	import ctl_chan_pkg::*;
	logic       clk, arst_n, seq_err_evt, rx_lock, id_load_valid, pass_through_en;
	logic       sda_drive_low, scl_drive_low, hold_sda_low, reg_rvalid, reg_wr_rejected;
	logic       txn_local, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
	logic       bus_free, bus_recovering;
	logic [6:0] id_load_value, alias_0, alias_1, far_id, ra;
	logic [7:0] reg_rdata, rd_v, slot0, slot1;
	reg_req_t   reg_req;
	txn_t       txn_in, txn_fwd;
	int         miscompares, n_compared, n, k;

	ctl_channel_i2c_remap_regs #(.WD_SLOW_CYC(24'h0007d0)) dut (.clk(clk), .arst_n(arst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_wr_rejected(reg_wr_rejected), .seq_err_evt(seq_err_evt), .rx_lock(rx_lock),
		.id_load_valid(id_load_valid), .id_load_value(id_load_value),
		.pass_through_en(pass_through_en), .alias_0(alias_0), .alias_1(alias_1),
		.txn_in(txn_in), .txn_fwd(txn_fwd), .txn_local(txn_local), .scl_in(scl_in),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe(sda_oe), .sda_drive_low(sda_drive_low), .scl_drive_low(scl_drive_low),
		.bus_free(bus_free), .bus_recovering(bus_recovering));
	i2c_far_end u_far (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_sda_low(hold_sda_low),
		.scl_in(scl_in), .sda_in(sda_in));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
		@(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, remote: rem, addr: a, wdata: d};
		@(posedge clk) reg_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, remote: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk) reg_req <= '0;
		#1 chk({reg_rvalid, reg_rdata}, {1'b1, exp});
	endtask
	task automatic tx(input logic [6:0] a, input logic [8:0] exp);
		@(posedge clk) txn_in <= '{valid: 1'b1, addr: a};
		@(posedge clk) txn_in <= '0;
		#1 chk({txn_fwd.valid, txn_local, txn_fwd.valid ? txn_fwd.addr : 7'h00}, exp);
	endtask
	// Expected {forwarded, local, address}; alias 0 wins over alias 1 over the ID
	function automatic logic [8:0] fwd_exp(input logic [6:0] a, input logic pass);
		if (!pass || a == 7'h00) return 9'h080;
		if (a == alias_0) return {2'b10, slot0[7:1]};
		if (a == alias_1) return {2'b10, slot1[7:1]};
		if (a == far_id) return {2'b10, a};
		return 9'h080;
	endfunction
	task automatic wait_free(input int lo, input int hi);
		@(posedge clk) hold_sda_low <= 1'b1;
		@(posedge clk) hold_sda_low <= 1'b0;
		k = 0;
		do begin @(posedge clk); #1; k++; end while (!bus_free && k < 3000);
		chk(k >= lo && k <= hi, 1);
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(100 * 20000);
		miscompares++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{arst_n, seq_err_evt, rx_lock, id_load_valid, pass_through_en} = '0;
		{sda_drive_low, scl_drive_low, hold_sda_low, id_load_value, alias_0, alias_1} = '0;
		{reg_req, txn_in, miscompares, n_compared, far_id} = '0;
		void'($urandom(32'h7efa));
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 6; a < 11; a++) rd(a[7:0], 8'h00);
		repeat (4) for (int a = 6; a < 11; a++) begin
			rd_v = $urandom;
			wr(a[7:0], rd_v, 1'b0);
			rd(a[7:0], (a == 6) ? (rd_v & 8'h5f) : (a == 10) ? 8'h00 : rd_v);
		end
		wr(OFS_I2C_CONTROL_TWO, 8'h00, 1'b0);
		wr(OFS_REMOTE_SERIALIZER_ID, 8'h00, 1'b0);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk) seq_err_evt <= 1'b1;
			@(posedge clk) seq_err_evt <= 1'b0;
			repeat (3) @(posedge clk);
			rd(OFS_I2C_CONTROL_TWO, 8'h80);
			wr(OFS_I2C_CONTROL_TWO, 8'h40, 1'b0);
			rd(OFS_I2C_CONTROL_TWO, 8'h40);
			wr(OFS_I2C_CONTROL_TWO, 8'h00, 1'b0);
		end
		wr(OFS_I2C_CONTROL_TWO, 8'h04, 1'b0);
		wr(OFS_REMOTE_SERIALIZER_ID, 8'h22, 1'b1);
		#1 chk(reg_wr_rejected, 1);
		wr(OFS_I2C_CONTROL_TWO, 8'h00, 1'b1);
		rd(OFS_REMOTE_SERIALIZER_ID, 8'h00);
		rd(OFS_I2C_CONTROL_TWO, 8'h04);
		wr(OFS_I2C_CONTROL_TWO, 8'h00, 1'b0);
		wr(OFS_REMOTE_SERIALIZER_ID, 8'h22, 1'b1);
		rd(OFS_REMOTE_SERIALIZER_ID, 8'h22);
		rd_v = {7'($urandom_range(1, 127)), 1'b0};
		@(posedge clk) rx_lock <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			repeat (2) @(posedge clk);
			id_load_value <= rd_v[7:1];
			id_load_valid <= 1'b1;
			@(posedge clk) id_load_valid <= 1'b0;
			rd(OFS_REMOTE_SERIALIZER_ID, (f == 0) ? rd_v : 8'h2b);
			if (f == 0) wr(OFS_REMOTE_SERIALIZER_ID, 8'h2b, 1'b0);
		end
		far_id = 7'h15;
		slot0 = $urandom;
		slot1 = $urandom;
		wr(OFS_REMOTE_SLAVE_ADDR_0, slot0, 1'b0);
		wr(OFS_REMOTE_SLAVE_ADDR_1, slot1, 1'b0);
		@(posedge clk) alias_0 <= 7'($urandom_range(64, 95));
		alias_1 <= 7'($urandom_range(96, 127));
		for (int p = 0; p < 2; p++) begin
			@(posedge clk) pass_through_en <= (p == 0);
			ra = 7'($urandom_range(22, 63));
			tx(alias_0, fwd_exp(alias_0, p == 0));
			tx(alias_1, fwd_exp(alias_1, p == 0));
			tx(far_id, fwd_exp(far_id, p == 0));
			tx(ra, fwd_exp(ra, p == 0));
		end
		@(posedge clk) alias_0 <= 7'h00;
		pass_through_en <= 1'b1;
		wr(OFS_REMOTE_SERIALIZER_ID, 8'h01, 1'b0);
		tx(7'h00, 9'h080);
		@(posedge clk) scl_drive_low <= 1'b1;
		@(posedge clk) scl_drive_low <= 1'b0;
		#1 chk(scl_oe, 1);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_I2C_CONTROL_TWO, {3'b000, c[1:0], 3'b010}, 1'b0);
			@(posedge clk) sda_drive_low <= 1'b1;
			k = 0;
			do begin @(posedge clk); #1; k++; end while (!sda_oe && k < 10);
			chk(k, (c < 2) ? 3 : 4);
			@(posedge clk) sda_drive_low <= 1'b0;
			repeat (6) @(posedge clk);
		end
		wait_free(495, 515);
		// A hung slave holds SDA low through recovery until the bench releases it
		@(posedge clk) hold_sda_low <= 1'b1;
		k = 0;
		while (!bus_recovering && k < 700) begin @(posedge clk); #1; k++; end
		chk(bus_recovering, 1);
		n = 0;
		rd_v[0] = 1'b0;
		while (bus_recovering && k < 2000) begin
			@(posedge clk);
			#1 k++;
			if (scl_oe && !rd_v[0]) n++;
			rd_v[0] = scl_oe;
		end
		chk(n, 9);
		wr(OFS_I2C_CONTROL_TWO, 8'h03, 1'b0);
		repeat (700) @(posedge clk);
		#1 chk({bus_free, bus_recovering}, 0);
		@(posedge clk) hold_sda_low <= 1'b0;
		wr(OFS_I2C_CONTROL_TWO, 8'h00, 1'b0);
		wait_free(1995, 2015);
		wrap_up();
	end
endmodule // tb
